/* dcp_med_div.sv */
// Medium-speed divider producing the system prescaler advance tick
`timescale 1ns/1ps
module dcp_med_div (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic enable,
   input wire logic [1:0] divide_sel,
   output logic tick
);
   import dcp_pkg::*;
   logic [5:0] count_reg;
   logic [5:0] last;
   always_comb begin
      case (divide_sel)
         MSD_DIV64: last = MSD_LAST64;
         MSD_DIV32: last = MSD_LAST32;
         MSD_DIV16: last = MSD_LAST16;
         MSD_DIV8: last = MSD_LAST8;
         default: last = MSD_LAST64;
      endcase
   end
   always_ff @(posedge clock) begin
      if (sys_rst || !enable || count_reg >= last) begin
         count_reg <= 6'h00;
      end else begin
         count_reg <= count_reg + 6'h01;
      end
   end
   assign tick = enable && (count_reg >= last);
endmodule

/* dcp_pkg.sv */
// Package with constants for the dual clock prescaler block
package dcp_pkg;
   localparam int SYS_WIDTH = 13;
   localparam int WATCH_WIDTH = 5;
   localparam logic [12:0] SYS_RESET = 13'h0000;
   localparam logic [4:0] WATCH_RESET = 5'h00;
   // Subclock input tick divided by four before the watch prescaler
   localparam logic [1:0] SUB_DIV_LAST = 2'h3;
   // Register map of the plain port
   localparam logic [3:0] ADDR_SYSCTL = 4'h0;
   localparam logic [3:0] ADDR_TMODE = 4'h1;
   localparam logic [3:0] ADDR_STATUS = 4'h2;
   // Field positions
   localparam int MSD_LO_POS = 0;
   localparam int MSD_HI_POS = 1;
   localparam int MED_SPEED_POS = 2;
   localparam int SYS_HALT_POS = 3;
   localparam int TCS_MID_POS = 2;
   localparam int TCS_HI_POS = 3;
   localparam logic [3:0] SYSCTL_RESET = 4'h0;
   localparam logic [3:0] TMODE_RESET = 4'h0;
   // Medium-speed divide codes and factors
   localparam logic [1:0] MSD_DIV64 = 2'h0;
   localparam logic [1:0] MSD_DIV32 = 2'h1;
   localparam logic [1:0] MSD_DIV16 = 2'h2;
   localparam logic [1:0] MSD_DIV8 = 2'h3;
   localparam logic [5:0] MSD_LAST64 = 6'h3f;
   localparam logic [5:0] MSD_LAST32 = 6'h1f;
   localparam logic [5:0] MSD_LAST16 = 6'h0f;
   localparam logic [5:0] MSD_LAST8 = 6'h07;
   typedef enum logic [1:0] {
      DCP_RUN = 2'b00,
      DCP_MEDIUM = 2'b01,
      DCP_HALTED = 2'b10
   } dcp_mode_t;
endpackage

/* dcp_prescalers.sv */
// Top of the dual clock prescaler block: system and watch prescalers
//
// Functional notes
// RQ1: System prescaler is 13-bit, +1 per clock
// RQ2: Reset clears system prescaler, counts after release
// RQ3: Halted oscillator stops and clears system prescaler
// RQ4: No software path to the system count
// RQ5: Taps /2../8192 system, /2../128 watch; the 5 watch taps here give subclock /8../128
// RQ6: Taps shared; each peripheral selects its own
// RQ7: Medium speed feeds divided clock to prescaler
// RQ8: Divide select offers 1/64, 1/32, 1/16, 1/8
// RQ9: Watch prescaler 5-bit, subclock divided by four
// RQ10: Reset clears watch prescaler, counts after release
// RQ11: Watch prescaler runs in all low-power modes
// RQ12: Both clock-select bits written one clear watch
// RQ13: Watch taps routed to timekeeping timer
// RQ14: Both counters wrap; taps from counter bits
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module dcp_prescalers (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rdata,
   input wire logic sub_tick,
   output logic [dcp_pkg::SYS_WIDTH-1:0] sys_taps,
   output logic [dcp_pkg::WATCH_WIDTH-1:0] watch_taps,
   output logic [dcp_pkg::WATCH_WIDTH-1:0] timekeeping_taps
);
   import dcp_pkg::*;

   logic [3:0] system_control_one_reg;
   logic [3:0] timekeeping_timer_mode_reg;
   logic [SYS_WIDTH-1:0] system_clock_prescaler_reg;
   logic [WATCH_WIDTH-1:0] watch_clock_prescaler_reg;
   logic [1:0] sub_phase_reg;
   logic [5:0] med_gap_reg;
   logic [5:0] chk_last;
   dcp_mode_t mode;
   logic med_tick;
   logic watch_tick;
   logic sys_advance;
   logic watch_clear;
   logic [1:0] divide_sel;

   assign divide_sel = {system_control_one_reg[MSD_HI_POS], system_control_one_reg[MSD_LO_POS]};

   always_comb begin
      if (system_control_one_reg[SYS_HALT_POS]) begin
         mode = DCP_HALTED;
      end else if (system_control_one_reg[MED_SPEED_POS]) begin
         mode = DCP_MEDIUM;
      end else begin
         mode = DCP_RUN;
      end
   end

   // Control registers; halt bit stands for standby/watch/sub modes
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         system_control_one_reg <= SYSCTL_RESET;
      end else if (wr_en && addr == ADDR_SYSCTL) begin
         system_control_one_reg <= wdata[3:0];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         timekeeping_timer_mode_reg <= TMODE_RESET;
      end else if (wr_en && addr == ADDR_TMODE) begin
         timekeeping_timer_mode_reg <= wdata[3:0];
      end
   end

   // Clear pulse when software writes ones to both select bits
   assign watch_clear = wr_en && addr == ADDR_TMODE && wdata[TCS_HI_POS] && wdata[TCS_MID_POS]; // [RQ12]

   // Read path: system count is not visible
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rdata <= 8'h00;
      end else if (rd_en) begin
         case (addr)
            ADDR_SYSCTL: rdata <= {4'h0, system_control_one_reg};
            ADDR_TMODE: rdata <= {4'h0, timekeeping_timer_mode_reg};
            ADDR_STATUS: rdata <= {3'h0, watch_clock_prescaler_reg}; // [RQ4]
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   dcp_med_div u_med_div (
      .clock(clock),
      .sys_rst(sys_rst),
      .enable(mode == DCP_MEDIUM),
      .divide_sel(divide_sel),
      .tick(med_tick)
   );

   dcp_watch_div u_watch_div (
      .clock(clock),
      .sys_rst(sys_rst),
      .sub_tick(sub_tick),
      .tick(watch_tick)
   );

   always_comb begin
      case (mode)
         DCP_RUN: sys_advance = 1'b1; // [RQ1]
         DCP_MEDIUM: sys_advance = med_tick; // [RQ7] [RQ8]
         DCP_HALTED: sys_advance = 1'b0;
         default: sys_advance = 1'b0;
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         system_clock_prescaler_reg <= SYS_RESET; // [RQ2]
      end else if (mode == DCP_HALTED) begin
         system_clock_prescaler_reg <= SYS_RESET; // [RQ3]
      end else if (sys_advance) begin
         system_clock_prescaler_reg <= system_clock_prescaler_reg + 13'h0001; // [RQ1] [RQ14]
      end
   end

   // Watch prescaler ignores the halt bit
   always_ff @(posedge clock) begin
      if (sys_rst || watch_clear) begin
         watch_clock_prescaler_reg <= WATCH_RESET; // [RQ10] [RQ12]
      end else if (watch_tick) begin
         watch_clock_prescaler_reg <= watch_clock_prescaler_reg + 5'h01; // [RQ9] [RQ11] [RQ14]
      end
   end

   // System tap n carries the clock divided by 2^(n+1) in run mode; watch tap n carries the subclock divided by 2^(n+3)
   assign sys_taps = system_clock_prescaler_reg; // [RQ5] [RQ6]
   assign watch_taps = watch_clock_prescaler_reg; // [RQ5]
   assign timekeeping_taps = watch_clock_prescaler_reg; // [RQ13]

   // Checker-only phase of the subclock pulses, kept apart from the divider
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sub_phase_reg <= 2'h0;
      end else if (sub_tick) begin
         sub_phase_reg <= sub_phase_reg + 2'h1;
      end
   end

   // Checker-only count of clocks since the last medium-speed step
   always_ff @(posedge clock) begin
      if (sys_rst || mode != DCP_MEDIUM || sys_advance) begin
         med_gap_reg <= 6'h00;
      end else begin
         med_gap_reg <= med_gap_reg + 6'h01;
      end
   end

   // Checker-only last gap value for the selected divide code
   always_comb begin
      case (divide_sel)
         MSD_DIV32: chk_last = MSD_LAST32;
         MSD_DIV16: chk_last = MSD_LAST16;
         MSD_DIV8: chk_last = MSD_LAST8;
         default: chk_last = MSD_LAST64;
      endcase
   end

   a_sys_count_step: assert property (@(posedge clock) disable iff (sys_rst) // [RQ1]
      (mode == DCP_RUN && $past(mode == DCP_RUN) && !$past(sys_rst))
      |-> system_clock_prescaler_reg == $past(system_clock_prescaler_reg) + 13'h0001)
      else $error("system prescaler did not step by one");

   a_sys_reset_zero: assert property (@(posedge clock) // [RQ2]
      $past(sys_rst) |-> system_clock_prescaler_reg == SYS_RESET)
      else $error("system prescaler not cleared by reset");

   a_sys_halt_clear: assert property (@(posedge clock) disable iff (sys_rst) // [RQ3]
      mode == DCP_HALTED |=> system_clock_prescaler_reg == SYS_RESET
         || !$past(mode == DCP_HALTED))
      else $error("system prescaler not held clear while halted");

   a_med_slow: assert property (@(posedge clock) disable iff (sys_rst) // [RQ7]
      (mode == DCP_MEDIUM && sys_advance) |=> (!sys_advance || mode != DCP_MEDIUM) [*7])
      else $error("medium speed advanced faster than 1/8");

   a_watch_reset_zero: assert property (@(posedge clock) // [RQ10]
      $past(sys_rst) |-> watch_clock_prescaler_reg == WATCH_RESET)
      else $error("watch prescaler not cleared by reset");

   a_watch_clear_write: assert property (@(posedge clock) disable iff (sys_rst) // [RQ12]
      watch_clear |=> watch_clock_prescaler_reg == WATCH_RESET)
      else $error("watch prescaler not cleared by select write");

   a_watch_in_halt: assert property (@(posedge clock) disable iff (sys_rst) // [RQ11]
      (watch_tick && !watch_clear && mode == DCP_HALTED)
      |=> watch_clock_prescaler_reg == $past(watch_clock_prescaler_reg) + 5'h01)
      else $error("watch prescaler stopped in low-power mode");

   a_watch_div_four: assert property (@(posedge clock) disable iff (sys_rst) // [RQ9]
      watch_tick |-> (sub_tick && sub_phase_reg == SUB_DIV_LAST))
      else $error("watch tick not on every fourth subclock pulse");

   a_watch_div_due: assert property (@(posedge clock) disable iff (sys_rst) // [RQ9]
      (sub_tick && sub_phase_reg == SUB_DIV_LAST) |-> watch_tick)
      else $error("fourth subclock pulse gave no watch tick");

   a_watch_step: assert property (@(posedge clock) disable iff (sys_rst) // [RQ9]
      ($past(watch_tick) && !$past(watch_clear) && !$past(sys_rst))
      |-> watch_clock_prescaler_reg == $past(watch_clock_prescaler_reg) + 5'h01)
      else $error("watch prescaler did not step on its tick");

   a_watch_hold: assert property (@(posedge clock) disable iff (sys_rst) // [RQ9]
      (!$past(watch_tick) && !$past(watch_clear) && !$past(sys_rst))
      |-> watch_clock_prescaler_reg == $past(watch_clock_prescaler_reg))
      else $error("watch prescaler moved without a tick");

   a_watch_wrap: assert property (@(posedge clock) disable iff (sys_rst) // [RQ14]
      ($past(watch_tick) && !$past(watch_clear) && !$past(sys_rst)
         && $past(watch_clock_prescaler_reg) == '1)
      |-> watch_clock_prescaler_reg == WATCH_RESET)
      else $error("watch prescaler did not wrap to zero");

   a_sys_halt_hold: assert property (@(posedge clock) disable iff (sys_rst) // [RQ3]
      (mode == DCP_HALTED && $past(mode == DCP_HALTED) && !$past(sys_rst))
      |-> system_clock_prescaler_reg == SYS_RESET)
      else $error("system prescaler not zero during halt");

   a_sys_no_jump: assert property (@(posedge clock) disable iff (sys_rst) // [RQ14]
      (!$past(sys_rst) && $past(mode) != DCP_HALTED)
      |-> (system_clock_prescaler_reg == $past(system_clock_prescaler_reg)
         || system_clock_prescaler_reg == $past(system_clock_prescaler_reg) + 13'h0001))
      else $error("system prescaler jumped");

   a_sys_wrap: assert property (@(posedge clock) disable iff (sys_rst) // [RQ14]
      ($past(mode == DCP_RUN) && !$past(sys_rst) && $past(system_clock_prescaler_reg) == '1)
      |-> system_clock_prescaler_reg == SYS_RESET)
      else $error("system prescaler did not wrap to zero");

   a_tap_bit_zero: assert property (@(posedge clock) disable iff (sys_rst) // [RQ5]
      ($past(mode == DCP_RUN) && !$past(sys_rst)) |-> sys_taps[0] != $past(sys_taps[0]))
      else $error("first system tap did not toggle each clock");

   a_med_step: assert property (@(posedge clock) disable iff (sys_rst) // [RQ7]
      ($past(mode == DCP_MEDIUM) && $past(sys_advance) && !$past(sys_rst))
      |-> system_clock_prescaler_reg == $past(system_clock_prescaler_reg) + 13'h0001)
      else $error("medium speed tick did not step the prescaler");

   a_med_hold: assert property (@(posedge clock) disable iff (sys_rst) // [RQ7]
      ($past(mode == DCP_MEDIUM) && !$past(sys_advance) && !$past(sys_rst))
      |-> system_clock_prescaler_reg == $past(system_clock_prescaler_reg))
      else $error("prescaler moved between medium speed ticks");

   a_med_div64: assert property (@(posedge clock) disable iff (sys_rst) // [RQ8]
      (mode == DCP_MEDIUM && divide_sel == MSD_DIV64 && sys_advance)
      |-> med_gap_reg >= MSD_LAST64)
      else $error("divide by 64 stepped early");

   a_med_div32: assert property (@(posedge clock) disable iff (sys_rst) // [RQ8]
      (mode == DCP_MEDIUM && divide_sel == MSD_DIV32 && sys_advance)
      |-> med_gap_reg >= MSD_LAST32)
      else $error("divide by 32 stepped early");

   a_med_div16: assert property (@(posedge clock) disable iff (sys_rst) // [RQ8]
      (mode == DCP_MEDIUM && divide_sel == MSD_DIV16 && sys_advance)
      |-> med_gap_reg >= MSD_LAST16)
      else $error("divide by 16 stepped early");

   a_med_div8: assert property (@(posedge clock) disable iff (sys_rst) // [RQ8]
      (mode == DCP_MEDIUM && divide_sel == MSD_DIV8 && sys_advance)
      |-> med_gap_reg >= MSD_LAST8)
      else $error("divide by 8 stepped early");

   a_med_tick_due: assert property (@(posedge clock) disable iff (sys_rst) // [RQ8]
      (mode == DCP_MEDIUM && med_gap_reg == chk_last) |-> sys_advance)
      else $error("medium speed step missing at end of period");

   a_rd_idle_zero: assert property (@(posedge clock) disable iff (sys_rst) // [RQ4]
      (!$past(rd_en) && !$past(sys_rst)) |-> rdata == 8'h00)
      else $error("read data not zero outside a read");

   a_rd_status: assert property (@(posedge clock) disable iff (sys_rst) // [RQ4]
      ($past(rd_en) && $past(addr) == ADDR_STATUS && !$past(sys_rst))
      |-> rdata == {3'h0, $past(watch_clock_prescaler_reg)})
      else $error("status read did not return watch count");

   a_rd_unmapped: assert property (@(posedge clock) disable iff (sys_rst) // [RQ4]
      ($past(rd_en) && $past(addr) > ADDR_STATUS && !$past(sys_rst)) |-> rdata == 8'h00)
      else $error("unmapped read returned data");

   a_ctl_write: assert property (@(posedge clock) disable iff (sys_rst) // [RQ3]
      ($past(wr_en) && $past(addr) == ADDR_SYSCTL && !$past(sys_rst))
      |-> system_control_one_reg == $past(wdata[3:0]))
      else $error("control write did not land");

   a_tmode_keep: assert property (@(posedge clock) disable iff (sys_rst) // [RQ12]
      watch_clear
      |=> (timekeeping_timer_mode_reg[TCS_HI_POS] && timekeeping_timer_mode_reg[TCS_MID_POS]))
      else $error("clock select bits not stored after clear write");

   a_tap_routing: assert property (@(posedge clock) // [RQ13]
      timekeeping_taps == watch_taps && watch_taps == watch_clock_prescaler_reg)
      else $error("timekeeping taps not routed from watch prescaler");
endmodule

/* dcp_sub_model.sv */
// Subclock source model: sends a counted burst of subclock pulses
`timescale 1ns/1ps
module dcp_sub_model (
   input wire logic clock,
   input wire logic load,
   input wire logic [7:0] n_ticks,
   output logic sub_tick,
   output logic idle
);
   logic [7:0] left_reg = 8'h00;
   logic [1:0] gap_reg = 2'h0;
   initial sub_tick = 1'b0;
   // Subclock stands still once the burst is spent
   always @(posedge clock) begin
      sub_tick <= 1'b0;
      if (load) begin
         left_reg <= n_ticks;
         gap_reg <= 2'h0;
      end else if (left_reg != 8'h00) begin
         gap_reg <= gap_reg + 2'h1;
         if (gap_reg == 2'h2) begin
            sub_tick <= 1'b1;
            left_reg <= left_reg - 8'h01;
            gap_reg <= 2'h0;
         end
      end
   end
   assign idle = (left_reg == 8'h00) && !sub_tick && !load;
endmodule

/* dcp_watch_div.sv */
// Fixed divide-by-four on the subclock tick for the watch prescaler
`timescale 1ns/1ps
module dcp_watch_div (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic sub_tick,
   output logic tick
);
   import dcp_pkg::*;
   logic [1:0] count_reg;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         count_reg <= 2'h0;
      end else if (sub_tick) begin
         count_reg <= count_reg + 2'h1;
      end
   end
   assign tick = sub_tick && (count_reg == SUB_DIV_LAST);
endmodule

/* tb_top.sv */
// Self-checking testbench for the dual clock prescaler block
`timescale 1ns/1ps
module tb_top;
   import dcp_pkg::*;
   logic clock = 1'b0, sys_rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, load = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, n_ticks = 8'h00, rdata;
   logic sub_tick, idle, rd_prev = 1'b0;
   logic [12:0] sys_taps, s0;
   logic [4:0] watch_taps, tk_taps, k;
   logic [31:0] seed = 32'h754e_2aa5;
   logic [7:0] exp_q[$];
   int n_mismatch = 0, cmp_count = 0;
   initial begin
      forever #25 clock = ~clock;
   end
   dcp_prescalers DUT (.clock(clock), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sub_tick(sub_tick),
      .sys_taps(sys_taps), .watch_taps(watch_taps), .timekeeping_taps(tk_taps));
   dcp_sub_model partner (.clock(clock), .load(load), .n_ticks(n_ticks),
      .sub_tick(sub_tick), .idle(idle));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize();
      if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // For a read, d is the value expected back
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      wr_en <= wr;
      rd_en <= !wr;
      addr <= a;
      wdata <= d;
      if (!wr) exp_q.push_back(d);
      @(posedge clock);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
   endtask
   task automatic ticks(input logic [7:0] n);
      @(posedge clock);
      n_ticks <= n;
      load <= 1'b1;
      @(posedge clock);
      load <= 1'b0;
      for (int i = 0; i < 2000 && !idle; i++) begin
         @(posedge clock);
         #1;
      end
      if (!idle) begin
         n_mismatch++;
         summarize();
      end
   endtask
   always @(posedge clock) begin
      #1;
      if (rd_prev) chk("rdata", {5'h00, exp_q.pop_front()}, {5'h00, rdata});
      rd_prev = rd_en;
   end
   initial begin
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      #1;
      chk("sys", SYS_RESET, sys_taps);
      chk("watch", {8'h00, WATCH_RESET}, {8'h00, watch_taps});
      repeat (100) @(posedge clock);
      #1;
      chk("sys", 13'h0064, sys_taps);
      repeat (8192) @(posedge clock);
      #1;
      chk("sys wrap", 13'h0064, sys_taps);
      bus(1'b0, ADDR_SYSCTL, {4'h0, SYSCTL_RESET});
      bus(1'b0, ADDR_TMODE, {4'h0, TMODE_RESET});
      bus(1'b0, 4'h3, 8'h00);
      seed = lfsr(seed);
      k = seed[4:0];
      ticks({1'b0, k, 2'b00});
      bus(1'b0, ADDR_STATUS, {3'h0, k});
      chk("timekeeping", {8'h00, k}, {8'h00, tk_taps});
      chk("watch taps", {8'h00, k}, {8'h00, watch_taps});
      bus(1'b1, ADDR_SYSCTL, 8'h08);
      repeat (5) @(posedge clock);
      #1;
      chk("sys halted", 13'h0000, sys_taps);
      ticks(8'h84);
      bus(1'b0, ADDR_STATUS, {3'h0, k + 5'h01});
      chk("sys halted", 13'h0000, sys_taps);
      seed = lfsr(seed);
      bus(1'b1, 4'hf, seed[7:0]);
      bus(1'b1, ADDR_TMODE, 8'h0c);
      bus(1'b0, ADDR_TMODE, 8'h0c);
      bus(1'b0, ADDR_STATUS, 8'h00);
      // Each divide code: eight prescaler steps per eight divided periods
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, ADDR_SYSCTL, {6'h01, c[1:0]});
         bus(1'b0, ADDR_SYSCTL, {6'h01, c[1:0]});
         repeat (200) @(posedge clock);
         #1;
         s0 = sys_taps;
         repeat (1 << (9 - c)) @(posedge clock);
         #1;
         chk("medium", s0 + 13'h0008, sys_taps);
      end
      summarize();
   end
endmodule
